// File: csw_clock_switch.sv
// Clock source switch and Sleep/Idle controller with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module csw_clock_switch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Oscillator side, asynchronous
  input wire logic [3:0] osc_clk_in,
  input wire logic pll_lock_in,
  input wire logic osc_startup_done,
  input wire logic clock_fail_in,
  // Wake sources, asynchronous
  input wire logic wake_irq,
  input wire logic watchdog_timeout,
  // Clock and power controls
  output logic [3:0] osc_enable,
  output logic pll_enable,
  output logic [2:0] sys_clk_select,
  output logic cpu_halt,
  output logic periph_clk_off,
  output logic watchdog_clear,
  output logic monitor_active
);
  import csw_pkg::*;

  localparam logic [1:0] SEL_OSC = 2'h0;
  localparam logic [1:0] SEL_CFG = 2'h1;
  localparam logic [1:0] SEL_PWR = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  csw_state_t s;
  csw_state_t n;

  function automatic logic [1:0] reg_sel(input logic [3:0] a);
    case ({a[3:2], 2'b00})
      CSW_OSC_CTRL: reg_sel = SEL_OSC;
      CSW_CFG: reg_sel = SEL_CFG;
      CSW_PWR: reg_sel = SEL_PWR;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  function automatic logic [3:0] osc_of(input logic [2:0] src);
    osc_of = '0;
    case (src)
      SRC_PRI, SRC_PRI_PLL: osc_of[OSC_PRI] = 1'b1;
      SRC_SEC: osc_of[OSC_SEC] = 1'b1;
      SRC_LOW_POWER_RC_OSCILLATOR: osc_of[OSC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
      default: osc_of[OSC_FRC] = 1'b1;
    endcase
  endfunction

  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
  endfunction

  // External clocks need no start-up timer; crystals do
  function automatic logic needs_ost(input logic [2:0] src, input logic [1:0] sub);
    case (src)
      SRC_PRI, SRC_PRI_PLL: needs_ost = (sub != SUB_EXT);
      SRC_SEC: needs_ost = 1'b1;
      default: needs_ost = 1'b0;
    endcase
  endfunction

  // Partial keys fall back unless the second byte follows at once
  function automatic csw_key_t key_step(input csw_key_t k, input logic [7:0] b,
                                        input logic [7:0] first, input logic [7:0] second);
    if ((k == KEY_HALF) && (b == second)) begin
      key_step = KEY_OPEN;
    end else if (b == first) begin
      key_step = KEY_HALF;
    end else begin
      key_step = KEY_NONE;
    end
  endfunction

  always_comb begin
    logic do_wr;
    logic [1:0] wsel;
    logic hi_wr;
    logic lo_wr;
    logic lock_i;
    logic ost_i;
    logic fail_i;
    logic wake_i;
    logic new_edge;
    logic src_ready;
    logic switching;
    logic [15:0] rd;
    logic [3:0] want;
    do_wr = 1'b0;
    wsel = SEL_NONE;
    hi_wr = 1'b0;
    lo_wr = 1'b0;
    rd = '0;
    want = '0;
    n = s;
    n.wdt_clear = 1'b0;

    // Two-flop synchronisers; only the second stage is read
    n.clk_s1 = osc_clk_in;
    n.clk_s2 = s.clk_s1;
    n.clk_prev = s.clk_s2;
    n.misc_s1 = {watchdog_timeout, wake_irq, clock_fail_in, osc_startup_done, pll_lock_in};
    n.misc_s2 = s.misc_s1;
    lock_i = s.misc_s2[0];
    ost_i = s.misc_s2[1];
    fail_i = s.misc_s2[2];
    wake_i = s.misc_s2[3] || s.misc_s2[4];
    new_edge = |((s.clk_s2 & ~s.clk_prev) & osc_of(s.new_src));

    // Write address and data are caught independently
    if (awvalid && s.awready) begin
      n.waddr = awaddr;
      n.aw_held = 1'b1;
      n.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      n.wdata = wdata[15:0];
      n.wstrb = wstrb[1:0];
      n.w_held = 1'b1;
      n.wready = 1'b0;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    do_wr = s.aw_held && s.w_held && !s.bvalid;
    if (do_wr) begin
      wsel = reg_sel(s.waddr);
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.bvalid = 1'b1;
      n.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      hi_wr = (wsel == SEL_OSC) && s.wstrb[1];
      lo_wr = (wsel == SEL_OSC) && s.wstrb[0];
      // A write that misses a lane breaks that lane's key
      n.key_hi = KEY_NONE;
      n.key_lo = KEY_NONE;
    end

    // High byte: key bytes only advance the key, the write after it lands
    if (hi_wr) begin
      if (s.key_hi == KEY_OPEN) begin
        n.key_hi = KEY_NONE;
        if (!s.mon_cfg) begin
          n.new_src = s.wdata[OSC_NEW_LSB +: 3];
        end
      end else begin
        n.key_hi = key_step(s.key_hi, s.wdata[15:8], KEY_HI_FIRST, KEY_HI_SECOND);
      end
    end

    // Low byte: switch request and software clear of the fail flag
    if (lo_wr) begin
      if (s.key_lo == KEY_OPEN) begin
        n.key_lo = KEY_NONE;
        if (s.wdata[OSC_REQ_BIT] && !s.mon_cfg && (s.sw == SW_IDLE)) begin
          n.req = 1'b1;
        end
        if (!s.wdata[OSC_CF_BIT]) begin
          n.cf = 1'b0;
        end
      end else begin
        n.key_lo = key_step(s.key_lo, s.wdata[7:0], KEY_LO_FIRST, KEY_LO_SECOND);
      end
    end

    // Configuration word is taken once after reset, like a fuse
    if (do_wr && (wsel == SEL_CFG) && s.wstrb[0] && !s.cfg_done) begin
      n.cfg_done = 1'b1;
      n.mon_cfg = s.wdata[CFG_MON_BIT];
      n.por_src = s.wdata[CFG_POR_LSB +: 3];
      n.wdt_en = s.wdata[CFG_WDT_BIT];
      n.keep_on = s.wdata[CFG_KEEP_BIT];
      n.submode = s.wdata[CFG_SUB_LSB +: 2];
      n.cur_src = s.wdata[CFG_POR_LSB +: 3];
      n.new_src = s.wdata[CFG_POR_LSB +: 3];
    end

    // Power save entry
    if (do_wr && (wsel == SEL_PWR) && s.wstrb[0] && (s.ps == PS_RUN)) begin
      if (s.wdata[PWR_SLEEP_BIT]) begin
        n.ps = PS_PREP;
      end else if (s.wdata[PWR_IDLE_BIT]) begin
        n.ps = PS_IDLE;
        n.wdt_clear = s.wdt_en;
      end
    end

    // Lock status sets once the running PLL locks and holds until the PLL is disabled or a switch starts
    if (s.pll_en && lock_i) begin
      n.lock = 1'b1;
    end
    if (!s.pll_en) begin
      n.lock = 1'b0;
    end

    src_ready = (!needs_ost(s.new_src, s.submode) || ost_i) &&
                (!uses_pll(s.new_src) || s.lock);

    // Switch sequence; the CPU is never halted by it
    case (s.sw)
      SW_IDLE: begin
        if (s.req) begin
          if (s.new_src == s.cur_src) begin
            n.req = 1'b0;
          end else begin
            n.lock = 1'b0;
            n.cf = 1'b0;
            n.sw = SW_READY;
          end
        end
      end
      SW_READY: begin
        if (src_ready) begin
          n.settle = '0;
          n.sw = SW_COUNT;
        end
      end
      SW_COUNT: begin
        // Sleep freezes the switch so wake-up finds the source it left
        if (new_edge && !s.periph_off) begin
          n.settle = s.settle + 4'h1;
          if (s.settle == SETTLE_CYCLES - 4'h1) begin
            n.sw = SW_FINISH;
          end
        end
      end
      SW_FINISH: begin
        if (!s.periph_off) begin
          n.cur_src = s.new_src;
          n.req = 1'b0;
          n.sw = SW_IDLE;
        end
      end
      default: begin
        n.sw = SW_IDLE;
      end
    endcase

    // Sleep and Idle; a wake arriving during entry waits for it to finish
    case (s.ps)
      PS_RUN: begin
      end
      PS_PREP: begin
        n.wdt_clear = s.wdt_en;
        n.ps = PS_SLEEP;
      end
      PS_SLEEP, PS_IDLE: begin
        if (wake_i) begin
          n.ps = PS_RUN;
        end
      end
      default: begin
        n.ps = PS_RUN;
      end
    endcase

    // Switching disabled: status shows the power-up source, request stays low
    if (s.mon_cfg) begin
      n.cur_src = s.por_src;
      n.req = 1'b0;
      n.sw = SW_IDLE;
    end

    // Hardware set beats any clear in the same cycle
    if (fail_i && s.mon_active) begin
      n.cf = 1'b1;
    end

    // Oscillator enables from the next state so they line up with it
    switching = (n.sw != SW_IDLE);
    want = osc_of(n.cur_src);
    if (switching) begin
      want = want | osc_of(n.new_src);
    end
    if (n.wdt_en || !n.mon_cfg) begin
      want[OSC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
    end
    if (n.keep_on) begin
      want[OSC_SEC] = 1'b1;
    end
    n.pll_en = uses_pll(n.cur_src) || (switching && uses_pll(n.new_src));
    if (n.ps == PS_SLEEP) begin
      want = '0;
      want[OSC_LOW_POWER_RC_OSCILLATOR] = n.wdt_en;
      want[OSC_SEC] = n.keep_on;
      n.pll_en = 1'b0;
    end
    n.osc_en = want;
    n.sys_sel = n.cur_src;
    n.cpu_halt = (n.ps != PS_RUN);
    n.periph_off = (n.ps == PS_SLEEP) || (n.ps == PS_PREP);
    n.mon_active = !n.mon_cfg && (n.ps != PS_SLEEP);

    // Read channel
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (arvalid && s.arready) begin
      case (reg_sel(araddr))
        SEL_OSC: begin
          rd[OSC_CUR_LSB +: 3] = s.cur_src;
          rd[OSC_NEW_LSB +: 3] = s.new_src;
          rd[OSC_LOCK_BIT] = s.lock;
          rd[OSC_CF_BIT] = s.cf;
          rd[OSC_REQ_BIT] = s.req;
        end
        SEL_CFG: begin
          rd[CFG_MON_BIT] = s.mon_cfg;
          rd[CFG_POR_LSB +: 3] = s.por_src;
          rd[CFG_WDT_BIT] = s.wdt_en;
          rd[CFG_KEEP_BIT] = s.keep_on;
          rd[CFG_SUB_LSB +: 2] = s.submode;
          rd[CFG_DONE_BIT] = s.cfg_done;
        end
        SEL_PWR: begin
          rd[PWR_STATE_LSB +: 3] = s.ps;
          rd[PWR_BUSY_BIT] = (s.sw != SW_IDLE);
        end
        default: begin
          rd = '0;
        end
      endcase
      n.rdata = {16'h0000, rd};
      n.rresp = (reg_sel(araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      n.rvalid = 1'b1;
      n.arready = 1'b0;
    end
  end

  // Clock enable low freezes every flip-flop, synchronisers included
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= CSW_STATE_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign osc_enable = s.osc_en;
  assign pll_enable = s.pll_en;
  assign sys_clk_select = s.sys_sel;
  assign cpu_halt = s.cpu_halt;
  assign periph_clk_off = s.periph_off;
  assign watchdog_clear = s.wdt_clear;
  assign monitor_active = s.mon_active;

endmodule

`default_nettype wire

// File: csw_clock_switch_chk.sv
// Port-level assertion checker for the clock switch block
`timescale 1ns/1ps
`default_nettype none
module csw_clock_switch_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Wake and clock controls
  input wire logic wake_irq,
  input wire logic [3:0] osc_enable,
  input wire logic pll_enable,
  input wire logic [2:0] sys_clk_select,
  input wire logic cpu_halt,
  input wire logic periph_clk_off,
  input wire logic watchdog_clear,
  input wire logic monitor_active
);
  import csw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (ce && arvalid && arready |=> rvalid)
    else $error("read not answered");
  sleep_halt_a: assert property (periph_clk_off |-> cpu_halt)
    else $error("peripherals off while cpu runs");
  sleep_osc_a: assert property (periph_clk_off [*3] |->
    !monitor_active && !pll_enable && {osc_enable[2], osc_enable[0]} == 2'h0)
    else $error("clock left running in sleep");
  wdt_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear too long");
  wdt_halt_a: assert property (watchdog_clear |-> cpu_halt)
    else $error("watchdog clear outside halt");
  wake_exit_a: assert property ((wake_irq && cpu_halt && ce) [*3] |=> !cpu_halt)
    else $error("no wake on interrupt");
  sel_sleep_a: assert property (periph_clk_off |=> $stable(sys_clk_select))
    else $error("source changed in sleep");
  cover property (watchdog_clear && periph_clk_off);
  cover property (watchdog_clear && !periph_clk_off);
  cover property ($changed(sys_clk_select));
endmodule
`default_nettype wire

// File: csw_clock_switch_test.sv
// Self-checking bench for the clock switch block
`timescale 1ns/1ps
`default_nettype none
module csw_clock_switch_test;
  import csw_pkg::*;
  logic clk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pll_lock_in, osc_startup_done, clock_fail_in;
  logic wake_irq, watchdog_timeout, pll_enable, cpu_halt, periph_clk_off;
  logic watchdog_clear, monitor_active;
  logic [3:0] awaddr, araddr, wstrb, osc_clk_in, osc_enable;
  logic [2:0] awprot, arprot, sys_clk_select;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int err_total, n_compared, pri_edges, wdt_pulses;

  csw_clock_switch dut (.clk(clk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .osc_clk_in(osc_clk_in), .pll_lock_in(pll_lock_in),
    .osc_startup_done(osc_startup_done), .clock_fail_in(clock_fail_in),
    .wake_irq(wake_irq), .watchdog_timeout(watchdog_timeout), .osc_enable(osc_enable),
    .pll_enable(pll_enable), .sys_clk_select(sys_clk_select), .cpu_halt(cpu_halt),
    .periph_clk_off(periph_clk_off), .watchdog_clear(watchdog_clear),
    .monitor_active(monitor_active));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Oscillators only run while enabled, so a stopped source gives no edges
  initial begin
    osc_clk_in = 4'h0;
    forever #7 osc_clk_in = osc_clk_in ^ (osc_enable & {4{rst_b}});
  end
  always @(posedge osc_clk_in[0]) pri_edges++;
  always @(posedge clk) if (watchdog_clear === 1'b1) wdt_pulses++;

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 300) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s,
      input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid || n > 300) break;
    end
    bready <= 1'b0;
    @(posedge clk);
    tmo(n);
    chk(bresp, er);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
      input logic [1:0] er);
    int n;
    logic [31:0] d;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid || n > 300) break;
    end
    d = rdata;
    chk(rresp, er);
    rready <= 1'b0;
    @(posedge clk);
    tmo(n);
    chk(d & {16'h0000, m}, {16'h0000, e});
  endtask
  task automatic set_src(input logic [2:0] s);
    axi_wr(CSW_OSC_CTRL, {KEY_HI_FIRST, 8'h00}, 4'h2, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {KEY_HI_SECOND, 8'h00}, 4'h2, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {5'h00, s, 8'h00}, 4'h2, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {8'h00, KEY_LO_FIRST}, 4'h1, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {8'h00, KEY_LO_SECOND}, 4'h1, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, 16'h0009, 4'h1, RESP_OKAY);
  endtask
  task automatic wait_sel(input logic [2:0] s);
    int n;
    n = 0;
    while (sys_clk_select !== s && n <= 300) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (cpu_halt !== 1'b0 && n <= 300) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask

  task automatic s_reset_disabled;
    chk(osc_enable, 4'h4);
    rd_chk(CSW_OSC_CTRL, 16'hffff, 16'h0000, RESP_OKAY);
    rd_chk(4'hc, 16'hffff, 16'h0000, RESP_SLVERR);
    set_src(SRC_SEC);
    repeat (40) @(posedge clk);
    rd_chk(CSW_OSC_CTRL, 16'h7001, 16'h0000, RESP_OKAY);
    chk(sys_clk_select, SRC_FRC);
  endtask
  task automatic s_config_key;
    axi_wr(CSW_CFG, 16'h0010, 4'h3, RESP_OKAY);
    axi_wr(CSW_CFG, 16'h0001, 4'h3, RESP_OKAY);
    rd_chk(CSW_CFG, 16'h01ff, 16'h0110, RESP_OKAY);
    chk(monitor_active, 1'b1);
    chk(osc_enable, 4'hc);
    // Stray write between the key bytes must cancel the key
    axi_wr(CSW_OSC_CTRL, {KEY_HI_FIRST, 8'h00}, 4'h2, RESP_OKAY);
    axi_wr(CSW_CFG, 16'h0010, 4'h3, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {KEY_HI_SECOND, 8'h00}, 4'h2, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {5'h00, SRC_PRI, 8'h00}, 4'h2, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {8'h00, KEY_LO_FIRST}, 4'h1, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, {8'h00, KEY_LO_SECOND}, 4'h1, RESP_OKAY);
    axi_wr(CSW_OSC_CTRL, 16'h0009, 4'h1, RESP_OKAY);
    repeat (10) @(posedge clk);
    rd_chk(CSW_OSC_CTRL, 16'h7701, 16'h0000, RESP_OKAY);
  endtask
  task automatic s_switch;
    clock_fail_in <= 1'b1;
    repeat (6) @(posedge clk);
    clock_fail_in <= 1'b0;
    rd_chk(CSW_OSC_CTRL, 16'h0008, 16'h0008, RESP_OKAY);
    pri_edges = 0;
    set_src(SRC_PRI);
    rd_chk(CSW_OSC_CTRL, 16'h0001, 16'h0001, RESP_OKAY);
    wait_sel(SRC_PRI);
    chk(pri_edges >= 10, 1'b1);
    rd_chk(CSW_OSC_CTRL, 16'h7729, 16'h2200, RESP_OKAY);
    chk(osc_enable, 4'h9);
    set_src(SRC_FRC_PLL);
    repeat (80) @(posedge clk);
    chk(sys_clk_select, SRC_PRI);
    chk(pll_enable, 1'b1);
    pll_lock_in <= 1'b1;
    wait_sel(SRC_FRC_PLL);
    rd_chk(CSW_OSC_CTRL, 16'h7721, 16'h1120, RESP_OKAY);
    chk(osc_enable, 4'hc);
    // Secondary is a crystal: the switch must wait for the start-up timer
    osc_startup_done <= 1'b0;
    set_src(SRC_SEC);
    repeat (60) @(posedge clk);
    chk(sys_clk_select, SRC_FRC_PLL);
    chk(osc_enable, 4'he);
    osc_startup_done <= 1'b1;
    wait_sel(SRC_SEC);
    rd_chk(CSW_OSC_CTRL, 16'h7721, 16'h4400, RESP_OKAY);
    chk(osc_enable, 4'ha);
  endtask
  task automatic s_power;
    axi_wr(CSW_PWR, 16'h0001, 4'h1, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({cpu_halt, periph_clk_off, pll_enable, monitor_active}, 4'hc);
    chk(osc_enable, 4'h8);
    chk(wdt_pulses, 1);
    wake_irq <= 1'b1;
    wait_run();
    wake_irq <= 1'b0;
    chk(sys_clk_select, SRC_SEC);
    axi_wr(CSW_PWR, 16'h0002, 4'h1, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({cpu_halt, periph_clk_off}, 2'h2);
    chk(osc_enable, 4'ha);
    chk(wdt_pulses, 2);
    watchdog_timeout <= 1'b1;
    wait_run();
    watchdog_timeout <= 1'b0;
  endtask

  initial begin
    {err_total, n_compared, pri_edges, wdt_pulses} = '0;
    {rst_b, awvalid, wvalid, bready, arvalid, rready, pll_lock_in} = '0;
    {clock_fail_in, wake_irq, watchdog_timeout, awaddr, araddr, wstrb, wdata} = '0;
    ce = 1'b1;
    osc_startup_done = 1'b1;
    awprot = 3'h0;
    arprot = 3'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    s_reset_disabled();
    s_config_key();
    s_switch();
    s_power();
    give_verdict();
  end
endmodule

bind csw_clock_switch csw_clock_switch_chk chk_i (.clk(clk), .rst_b(rst_b), .ce(ce),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .wake_irq(wake_irq),
  .osc_enable(osc_enable), .pll_enable(pll_enable), .sys_clk_select(sys_clk_select),
  .cpu_halt(cpu_halt), .periph_clk_off(periph_clk_off), .watchdog_clear(watchdog_clear),
  .monitor_active(monitor_active));
`default_nettype wire

// File: csw_pkg.sv
// Constants, register map and state type for the clock switch and power save block
package csw_pkg;

  // Register byte offsets
  localparam logic [3:0] CSW_OSC_CTRL = 4'h0;
  localparam logic [3:0] CSW_CFG = 4'h4;
  localparam logic [3:0] CSW_PWR = 4'h8;

  // Oscillator control register fields
  localparam int OSC_REQ_BIT = 0;
  localparam int OSC_CF_BIT = 3;
  localparam int OSC_LOCK_BIT = 5;
  localparam int OSC_NEW_LSB = 8;
  localparam int OSC_CUR_LSB = 12;

  // Unlock keys
  localparam logic [7:0] KEY_HI_FIRST = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9a;
  localparam logic [7:0] KEY_LO_FIRST = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;

  // Clock source codes
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSCILLATOR = 3'h5;

  // Oscillator enable bit positions
  localparam int OSC_PRI = 0;
  localparam int OSC_SEC = 1;
  localparam int OSC_FRC = 2;
  localparam int OSC_LOW_POWER_RC_OSCILLATOR = 3;

  // Primary submodes
  localparam logic [1:0] SUB_EXT = 2'h0;
  localparam logic [1:0] SUB_XT = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;

  // Configuration register fields and reset values
  localparam int CFG_MON_BIT = 0;
  localparam int CFG_POR_LSB = 1;
  localparam int CFG_WDT_BIT = 4;
  localparam int CFG_KEEP_BIT = 5;
  localparam int CFG_SUB_LSB = 6;
  localparam int CFG_DONE_BIT = 8;
  localparam logic CFG_MON_RST = 1'b1;
  localparam logic [2:0] CFG_POR_RST = SRC_FRC;
  localparam logic [1:0] CFG_SUB_RST = SUB_XT;

  // Power register fields
  localparam int PWR_SLEEP_BIT = 0;
  localparam int PWR_IDLE_BIT = 1;
  localparam int PWR_STATE_LSB = 0;
  localparam int PWR_BUSY_BIT = 3;

  // New-clock cycles counted before the swap
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h3
  } csw_key_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_READY = 2'h1,
    SW_COUNT = 2'h3,
    SW_FINISH = 2'h2
  } csw_sw_t;

  typedef enum logic [2:0] {
    PS_RUN = 3'h0,
    PS_PREP = 3'h1,
    PS_SLEEP = 3'h3,
    PS_IDLE = 3'h2
  } csw_ps_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [3:0] waddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    csw_key_t key_hi;
    csw_key_t key_lo;
    logic mon_cfg;
    logic [2:0] por_src;
    logic wdt_en;
    logic keep_on;
    logic [1:0] submode;
    logic cfg_done;
    logic [2:0] cur_src;
    logic [2:0] new_src;
    logic req;
    logic lock;
    logic cf;
    csw_sw_t sw;
    logic [3:0] settle;
    csw_ps_t ps;
    logic [3:0] clk_s1;
    logic [3:0] clk_s2;
    logic [3:0] clk_prev;
    logic [4:0] misc_s1;
    logic [4:0] misc_s2;
    logic [3:0] osc_en;
    logic pll_en;
    logic [2:0] sys_sel;
    logic cpu_halt;
    logic periph_off;
    logic wdt_clear;
    logic mon_active;
  } csw_state_t;

  localparam csw_state_t CSW_STATE_RST = '{
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    key_hi: KEY_NONE,
    key_lo: KEY_NONE,
    mon_cfg: CFG_MON_RST,
    por_src: CFG_POR_RST,
    submode: CFG_SUB_RST,
    cur_src: CFG_POR_RST,
    new_src: CFG_POR_RST,
    sw: SW_IDLE,
    ps: PS_RUN,
    osc_en: 4'h4,
    sys_sel: CFG_POR_RST,
    default: '0
  };

endpackage
